/* rtl/pwmcsc_top.sv */
// three compare channels with state bits, events and level selection
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module pwmcsc_top #(
  parameter int NUM_CH = 3,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // period timer status
  input wire logic [15:0] timer_count,
  input wire logic count_direction,
  input wire logic timer_run_bit,
  input wire logic timer_tick,
  input wire logic timer_shadow_transfer,
  // overcurrent comparator pins
  input wire logic [2:0] hysteresis_input,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // channel results
  output logic [2:0] channel_match,
  output logic zero_match,
  output logic one_match,
  output logic [2:0] channel_state_bit,
  output logic [2:0] match_up_event,
  output logic [2:0] match_down_event,
  output logic [2:0] channel_pin
);

  // what a channel's mode field asks of it
  typedef enum {
    PWMCSC_OFF,
    PWMCSC_COMPARE,
    PWMCSC_HYST,
    PWMCSC_OTHER
  } pwmcsc_mode_t;

  // compare registers per channel
  logic [15:0] compare_shadow_value_ff [3];
  logic [15:0] active_compare_value_ff [3];
  // mode and level selection registers
  logic [11:0] mode_select_ff;
  logic [2:0] level_sel_ff;
  pwmcsc_mode_t ch_mode [3];
  logic [2:0] rules_on;
  // state bits and their next values
  logic [2:0] state_ff;
  logic [2:0] nxt_state;
  // conditions latched at one tick for the next
  logic [2:0] match_ff;
  logic [2:0] zero_and_match_ff;
  logic [2:0] zero_no_match_ff;
  logic [2:0] dir_at_match_ff;
  logic [2:0] run_at_match_ff;
  logic [2:0] pending_ff;
  // hysteresis synchroniser and filtered level
  logic [2:0] hyst_s1_ff;
  logic [2:0] hyst_s2_ff;
  logic [2:0] hyst_s3_ff;
  logic [2:0] hyst_level_ff;
  logic [2:0] hyst_mode;
  logic [2:0] hyst_block;
  // events, pins and read data
  logic [2:0] up_ev_ff;
  logic [2:0] down_ev_ff;
  logic [2:0] pin_ff;
  logic [2:0] nxt_pin;
  logic [15:0] rdata_ff;
  logic [15:0] rd_word;
  // register strobes decoded by address
  logic [2:0] shadow_wr;
  logic mod_wr;
  logic mode_wr;
  logic level_wr;
  // software requests and switching decisions
  logic [2:0] set_req;
  logic [2:0] clr_req;
  logic [2:0] rule_fire;
  logic [2:0] rule_value;

  // channel mode field
  function automatic logic [3:0] mode_of(input logic [11:0] m, input int ch);
    mode_of = m[ch*4 +: 4];
  endfunction

  // decode a mode field into the kind of channel it selects
  function automatic pwmcsc_mode_t mode_kind(input logic [3:0] code);
    unique case (code)
      pwmcsc_pkg::MSEL_OFF: mode_kind = PWMCSC_OFF;
      pwmcsc_pkg::MSEL_CMP_A,
      pwmcsc_pkg::MSEL_CMP_B,
      pwmcsc_pkg::MSEL_CMP_C: mode_kind = PWMCSC_COMPARE;
      pwmcsc_pkg::MSEL_HYST: mode_kind = PWMCSC_HYST;
      default: mode_kind = PWMCSC_OTHER;
    endcase
  endfunction

  // register offset of a channel's shadow value
  function automatic logic [3:0] shadow_addr(input int ch);
    shadow_addr = pwmcsc_pkg::ADDR_SHADOW0 + 4'(ch);
  endfunction

  // equality of the count and a compare value
  function automatic logic is_equal(input logic [15:0] a, input logic [15:0] b);
    is_equal = (a == b);
  endfunction

  // widen a three-bit field to a read word
  function automatic logic [15:0] widen3(input logic [2:0] v);
    widen3 = {13'h0000, v};
  endfunction

  // whether any switching rule applies to a channel
  function automatic logic rule_any(input logic hit, input logic zm, input logic znm);
    rule_any = hit || zm || znm;
  endfunction

  // level the switching rules give once a rule fires
  function automatic logic rule_level(input logic up_hit, input logic zm_hit);
    rule_level = up_hit || zm_hit; // RULE9 RULE10
  endfunction

  // counter flags
  assign zero_match = is_equal(timer_count, pwmcsc_pkg::ZERO_COUNT); // RULE22
  assign one_match = is_equal(timer_count, pwmcsc_pkg::ONE_COUNT); // RULE22

  // equality comparators, one per channel
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      channel_match[i] = is_equal(timer_count, active_compare_value_ff[i]); // RULE1
    end
  end

  // register write strobes
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      shadow_wr[i] = reg_wr && reg_addr == shadow_addr(i);
    end
  end
  assign mod_wr = reg_wr && reg_addr == pwmcsc_pkg::ADDR_STATE_MOD;
  assign mode_wr = reg_wr && reg_addr == pwmcsc_pkg::ADDR_MODE_SEL;
  assign level_wr = reg_wr && reg_addr == pwmcsc_pkg::ADDR_LEVEL_SEL;

  // compare shadow registers, written by software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        compare_shadow_value_ff[i] <= pwmcsc_pkg::RST_CMP; // RULE23
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (shadow_wr[i]) begin
          compare_shadow_value_ff[i] <= reg_wdata;
        end
      end
    end
  end

  // active compare registers, loaded only by shadow transfer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        active_compare_value_ff[i] <= pwmcsc_pkg::RST_CMP; // RULE23
      end
    end else if (timer_shadow_transfer) begin
      for (int i = 0; i < NUM_CH; i++) begin
        active_compare_value_ff[i] <= compare_shadow_value_ff[i]; // RULE2
      end
    end
  end

  // mode select register, four bits per channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_select_ff <= pwmcsc_pkg::RST_MSEL;
    end else if (mode_wr) begin
      mode_select_ff <= reg_wdata[11:0];
    end
  end

  // passive level select register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_sel_ff <= pwmcsc_pkg::RST_LEVEL;
    end else if (level_wr) begin
      level_sel_ff <= reg_wdata[2:0]; // RULE19
    end
  end

  // three-flop synchroniser for the comparator pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hyst_s1_ff <= 3'h7;
      hyst_s2_ff <= 3'h7;
      hyst_s3_ff <= 3'h7;
    end else begin
      hyst_s1_ff <= hysteresis_input; // RULE18
      hyst_s2_ff <= hyst_s1_ff;
      hyst_s3_ff <= hyst_s2_ff;
    end
  end

  // level accepted only when second and third flops agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hyst_level_ff <= 3'h7;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hyst_s2_ff[i] == hyst_s3_ff[i]) begin
          hyst_level_ff[i] <= hyst_s3_ff[i];
        end
      end
    end
  end

  // per-channel mode decode; hysteresis input acts only in its own mode
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_mode[i] = mode_kind(mode_of(mode_select_ff, i));
      rules_on[i] = ch_mode[i] == PWMCSC_COMPARE || ch_mode[i] == PWMCSC_HYST; // RULE3
      hyst_mode[i] = ch_mode[i] == PWMCSC_HYST; // RULE5 RULE16
      hyst_block[i] = hyst_mode[i] && !hyst_level_ff[i]; // RULE17
    end
  end

  // compare match away from zero, latched at each tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_ff <= 3'h0;
    end else if (timer_tick) begin
      match_ff <= channel_match & {3{!zero_match}};
    end
  end

  // zero match together with a compare match, counting up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      zero_and_match_ff <= 3'h0;
    end else if (timer_tick) begin
      zero_and_match_ff <= channel_match & {3{zero_match && !count_direction}}; // RULE10 RULE13
    end
  end

  // zero match without a compare match, counting up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      zero_no_match_ff <= 3'h0;
    end else if (timer_tick) begin
      zero_no_match_ff <= ~channel_match & {3{zero_match && !count_direction}}; // RULE12
    end
  end

  // count direction at the latching tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_at_match_ff <= 3'h0;
    end else if (timer_tick) begin
      dir_at_match_ff <= {3{count_direction}}; // RULE21
    end
  end

  // run bit at the latching tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_at_match_ff <= 3'h0;
    end else if (timer_tick) begin
      run_at_match_ff <= {3{timer_run_bit}}; // RULE8
    end
  end

  // first tick seen, so latched conditions are valid
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending_ff <= 3'h0;
    end else if (timer_tick) begin
      pending_ff <= 3'h7;
    end
  end

  // software set and clear requests; set wins if both are given
  always_comb begin
    set_req = 3'h0;
    clr_req = 3'h0;
    if (mod_wr) begin
      set_req = reg_wdata[pwmcsc_pkg::MOD_SET_POS +: 3];
      clr_req = reg_wdata[pwmcsc_pkg::MOD_CLR_POS +: 3] & ~set_req; // RULE4
    end
  end

  // which channels the switching rules move at this tick
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      rule_fire[i] = timer_tick && pending_ff[i] && run_at_match_ff[i] && timer_run_bit && rules_on[i]
        && rule_any(match_ff[i], zero_and_match_ff[i], zero_no_match_ff[i]); // RULE3 RULE8
      rule_value[i] = rule_level(match_ff[i] && !dir_at_match_ff[i], zero_and_match_ff[i]); // RULE14 RULE15
    end
  end

  // next state: rules, then software, then hysteresis block
  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < NUM_CH; i++) begin
      if (rule_fire[i]) begin
        nxt_state[i] = rule_value[i]; // RULE9 RULE11 RULE12 RULE13
      end
      if (set_req[i]) begin
        nxt_state[i] = 1'b1; // RULE4
      end else if (clr_req[i]) begin
        nxt_state[i] = 1'b0; // RULE4
      end
      if (hyst_block[i]) begin
        nxt_state[i] = 1'b0; // RULE16 RULE17
      end
    end
  end

  // state bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= pwmcsc_pkg::RST_STATE; // RULE23
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign channel_state_bit = state_ff;

  // up-count match events, independent of state bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_ev_ff <= 3'h0;
    end else begin
      up_ev_ff <= channel_match & {3{timer_tick && !count_direction}}; // RULE6 RULE7
    end
  end
  assign match_up_event = up_ev_ff;

  // down-count match events, independent of state bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      down_ev_ff <= 3'h0;
    end else begin
      down_ev_ff <= channel_match & {3{timer_tick && count_direction}}; // RULE6 RULE7
    end
  end
  assign match_down_event = down_ev_ff;

  // active state inverts the passive level
  assign nxt_pin = level_sel_ff ^ state_ff; // RULE19

  // pin register, one cycle behind the state bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_ff <= pwmcsc_pkg::RST_LEVEL;
    end else begin
      pin_ff <= nxt_pin;
    end
  end
  assign channel_pin = pin_ff;

  // read multiplexer by address; write-only and unmapped read zero
  always_comb begin
    rd_word = pwmcsc_pkg::RD_ZERO;
    case (reg_addr)
      pwmcsc_pkg::ADDR_SHADOW0: rd_word = compare_shadow_value_ff[0];
      pwmcsc_pkg::ADDR_SHADOW1: rd_word = compare_shadow_value_ff[1];
      pwmcsc_pkg::ADDR_SHADOW2: rd_word = compare_shadow_value_ff[2];
      pwmcsc_pkg::ADDR_ACTIVE0: rd_word = active_compare_value_ff[0];
      pwmcsc_pkg::ADDR_ACTIVE1: rd_word = active_compare_value_ff[1];
      pwmcsc_pkg::ADDR_ACTIVE2: rd_word = active_compare_value_ff[2];
      pwmcsc_pkg::ADDR_MODE_SEL: rd_word = {4'h0, mode_select_ff};
      pwmcsc_pkg::ADDR_CMP_STATE: rd_word = widen3(state_ff);
      pwmcsc_pkg::ADDR_LEVEL_SEL: rd_word = widen3(level_sel_ff);
      default: rd_word = pwmcsc_pkg::RD_ZERO;
    endcase
  end

  // read data register, data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= pwmcsc_pkg::RD_ZERO;
    end else if (reg_rd) begin
      rdata_ff <= rd_word;
    end else begin
      rdata_ff <= pwmcsc_pkg::RD_ZERO;
    end
  end
  assign reg_rdata = rdata_ff;

endmodule

/* inc/pwmcsc_pkg.sv */
// constants for the three-channel compare state logic
// How it works
// (RULE1) each channel compares timer count with its compare value for equality
// (RULE2) shadow compare value copies to active value only on shadow transfer
// (RULE3) state logic uses direction, run bit, zero match, channel match, mode
// (RULE4) software set and clear requests force each state bit directly
// (RULE5) hysteresis inputs are ignored in normal compare mode
// (RULE6) match while counting up raises up event, down raises down event
// (RULE7) match events do not depend on the state bit
// (RULE8) compare switching changes state bits only while timer runs
// (RULE9) tick after match counting up sets the state bit
// (RULE10) tick after zero match with compare match counting up sets state
// (RULE11) tick after match counting down clears the state bit
// (RULE12) tick after zero match without compare match counting up clears state
// (RULE13) compare value zero keeps state at one, full duty cycle
// (RULE14) change from one to zero still gives one low tick
// (RULE15) compare value period plus one never sets, zero duty cycle
// (RULE16) mode 1001 lets a low hysteresis input clear the state bit
// (RULE17) in hysteresis mode state held low while input low
// (RULE18) hysteresis inputs sampled on module clock, not timer tick
// (RULE19) passive output drives level select, active drives its inverse
// (RULE20) software picks passive level that keeps the power switch off
// (RULE21) direction flag zero counts up, one counts down
// (RULE22) zero match at count zero, one match at count one
// (RULE23) state bits, compare and shadow values reset to zero
package pwmcsc_pkg;
  localparam int NUM_CH = 3;
  localparam int CNT_W = 16;
  localparam int MSEL_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [3:0] ADDR_SHADOW0 = 4'h0;
  localparam logic [3:0] ADDR_SHADOW1 = 4'h1;
  localparam logic [3:0] ADDR_SHADOW2 = 4'h2;
  localparam logic [3:0] ADDR_ACTIVE0 = 4'h3;
  localparam logic [3:0] ADDR_ACTIVE1 = 4'h4;
  localparam logic [3:0] ADDR_ACTIVE2 = 4'h5;
  localparam logic [3:0] ADDR_MODE_SEL = 4'h6;
  localparam logic [3:0] ADDR_CMP_STATE = 4'h7;
  localparam logic [3:0] ADDR_STATE_MOD = 4'h8;
  localparam logic [3:0] ADDR_LEVEL_SEL = 4'h9;
  // field positions
  localparam int MOD_SET_POS = 0;
  localparam int MOD_CLR_POS = 8;
  // mode codes
  localparam logic [3:0] MSEL_OFF = 4'h0;
  localparam logic [3:0] MSEL_CMP_A = 4'h1;
  localparam logic [3:0] MSEL_CMP_B = 4'h2;
  localparam logic [3:0] MSEL_CMP_C = 4'h3;
  localparam logic [3:0] MSEL_HYST = 4'h9;
  // reset values
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [2:0] RST_STATE = 3'h0;
  localparam logic [11:0] RST_MSEL = 12'h000;
  localparam logic [2:0] RST_LEVEL = 3'h0;
  localparam logic [15:0] ZERO_COUNT = 16'h0000;
  localparam logic [15:0] ONE_COUNT = 16'h0001;
  localparam logic [15:0] RD_ZERO = 16'h0000;
endpackage

/* tb/pwmcsc_top_asserts.sv */
// port assertions for the compare channel block
`timescale 1ns/1ps
module pwmcsc_top_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // timer and register strobes
  input wire logic [15:0] timer_count,
  input wire logic count_direction,
  input wire logic timer_run_bit,
  input wire logic timer_tick,
  input wire logic reg_wr,
  input wire logic [2:0] hysteresis_input,
  // results
  input wire logic [2:0] channel_match,
  input wire logic zero_match,
  input wire logic one_match,
  input wire logic [2:0] channel_state_bit,
  input wire logic [2:0] match_up_event,
  input wire logic [2:0] match_down_event,
  input wire logic [2:0] channel_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [2:0] st1_ff;
  logic [2:0] st2_ff;
  logic [2:0] up_ff;
  logic wr1_ff;
  logic wr2_ff;
  // delayed copies for pin and event relations
  always_ff @(posedge ref_clk) begin
    st1_ff <= channel_state_bit;
    st2_ff <= st1_ff;
    wr1_ff <= reg_wr;
    wr2_ff <= wr1_ff;
    up_ff <= channel_match & {3{timer_tick && !count_direction}};
  end
  sequence up_hit_s;
    timer_tick && channel_match[0] && !count_direction;
  endsequence
  sequence down_hit_s;
    timer_tick && channel_match[0] && count_direction;
  endsequence
  sequence stopped_s;
    (!timer_run_bit && !reg_wr && &hysteresis_input) [*6];
  endsequence
  zero_flag_a: assert property (zero_match == (timer_count == 16'h0000)) else $error("zero match wrong");
  one_flag_a: assert property (one_match == (timer_count == 16'h0001)) else $error("one match wrong");
  up_event_a: assert property (up_hit_s |=> match_up_event[0]) else $error("up event missing");
  down_event_a: assert property (down_hit_s |=> match_down_event[0]) else $error("down event missing");
  event_indep_a: assert property (match_up_event == up_ff) else $error("up event wrong");
  stopped_hold_a: assert property (stopped_s |=> $stable(channel_state_bit)) else $error("state moved");
  pin_cause_a: assert property (channel_pin != $past(channel_pin) |-> st1_ff != st2_ff || wr2_ff)
    else $error("pin changed alone");
  reset_zero_a: assert property (disable iff (1'b0) rst |=> channel_state_bit == 3'h0 && channel_pin == 3'h0)
    else $error("reset state wrong");
endmodule

/* tb/pwmcsc_power_stage.sv */
// switch drivers and overcurrent comparator beside the block
`timescale 1ns/1ps
module pwmcsc_power_stage (
  // fault control and channel pins
  input wire logic [2:0] overcurrent,
  input wire logic [2:0] channel_pin,
  input wire logic [2:0] passive_level,
  // comparator output and switch state
  output logic [2:0] hysteresis_input,
  output logic [2:0] switch_on
);
  // comparator answers off the clock edge
  initial hysteresis_input = 3'h7;
  always @(overcurrent) hysteresis_input <= #3 ~overcurrent;
  // passive pin level keeps the switch off
  assign switch_on = channel_pin ^ passive_level;
endmodule

/* tb/pwmcsc_top_bench.sv */
// self-checking bench for the compare channel block
`timescale 1ns/1ps
module pwmcsc_top_bench;
  logic ref_clk, rst, count_direction, timer_run_bit, timer_tick, timer_shadow_transfer, reg_wr, reg_rd, prun;
  logic zero_match, one_match;
  logic [15:0] timer_count, reg_wdata, reg_rdata;
  logic [15:0] cmp [3];
  logic [3:0] reg_addr;
  logic [2:0] hysteresis_input, channel_match, channel_state_bit, match_up_event, match_down_event, channel_pin;
  logic [2:0] overcurrent, switch_on, exp_st, pset, pclr, lvl;
  int failures, check_count, cycles;
  pwmcsc_top dut (.ref_clk, .rst, .timer_count, .count_direction, .timer_run_bit, .timer_tick,
    .timer_shadow_transfer, .hysteresis_input, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .channel_match, .zero_match, .one_match, .channel_state_bit, .match_up_event, .match_down_event, .channel_pin);
  pwmcsc_power_stage model (.overcurrent, .channel_pin, .passive_level(lvl), .hysteresis_input, .switch_on);
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task check(string n, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(logic [3:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(logic [3:0] a, logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check("read data", reg_rdata, e);
    @(posedge ref_clk);
  endtask
  // one timer tick, then match, event and state checks
  task tick(logic [15:0] c, logic d, logic r);
    logic [2:0] hit;
    for (int i = 0; i < 3; i++) hit[i] = (c == cmp[i]);
    timer_count <= c;
    count_direction <= d;
    timer_run_bit <= r;
    timer_tick <= 1'b1;
    @(posedge ref_clk);
    timer_tick <= 1'b0;
    #1 check("match events", {7'h00, channel_match, match_up_event, match_down_event},
      {7'h00, hit, hit & {3{!d}}, hit & {3{d}}});
    if (prun && r) exp_st = (exp_st | pset) & ~pclr;
    pset = hit & {3{!d}};
    pclr = (hit & {3{d && c != 16'h0000}}) | (~hit & {3{!d && c == 16'h0000}});
    prun = r;
    repeat (2) @(posedge ref_clk);
    #1 check("state bit", {13'h0000, channel_state_bit}, {13'h0000, exp_st});
    @(posedge ref_clk);
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {timer_count, count_direction, timer_run_bit, timer_tick, timer_shadow_transfer} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, overcurrent, lvl, exp_st, pset, pclr, prun} = '0;
    {failures, check_count, cycles} = '0;
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 10; a++) rd(a[3:0], 16'h0000);
    rd(4'hF, 16'h0000);
    cmp[0] = 16'h0002;
    cmp[1] = 16'h0000;
    cmp[2] = 16'h0005;
    for (int i = 0; i < 3; i++) wr(i[3:0], cmp[i]);
    rd(pwmcsc_pkg::ADDR_ACTIVE0, 16'h0000);
    timer_shadow_transfer <= 1'b1;
    @(posedge ref_clk);
    timer_shadow_transfer <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) rd(pwmcsc_pkg::ADDR_ACTIVE0 + i[3:0], cmp[i]);
    wr(pwmcsc_pkg::ADDR_MODE_SEL, 16'h0111);
    lvl = 3'h5;
    wr(pwmcsc_pkg::ADDR_LEVEL_SEL, 16'h0005);
    wr(pwmcsc_pkg::ADDR_STATE_MOD, 16'h0007);
    rd(pwmcsc_pkg::ADDR_CMP_STATE, 16'h0007);
    wr(pwmcsc_pkg::ADDR_STATE_MOD, 16'h0700);
    rd(pwmcsc_pkg::ADDR_CMP_STATE, 16'h0000);
    for (int k = 0; k < 10; k++) tick(16'(k % 5), 1'b0, 1'b1);
    for (int k = 0; k < 10; k++) tick(16'(k <= 5 ? k : 10 - k), k > 5, 1'b1);
    tick(16'h0002, 1'b0, 1'b0);
    tick(16'h0003, 1'b0, 1'b0);
    wr(pwmcsc_pkg::ADDR_MODE_SEL, 16'h0119);
    wr(pwmcsc_pkg::ADDR_STATE_MOD, 16'h0007);
    exp_st = 3'h6;
    overcurrent <= 3'h7;
    repeat (8) @(posedge ref_clk);
    #1 check("state bit", {13'h0000, channel_state_bit}, {13'h0000, exp_st});
    check("pin level", {13'h0000, channel_pin}, {13'h0000, lvl ^ exp_st});
    check("switch on", {13'h0000, switch_on}, {13'h0000, exp_st});
    @(posedge ref_clk);
    wr(pwmcsc_pkg::ADDR_STATE_MOD, 16'h0001);
    rd(pwmcsc_pkg::ADDR_CMP_STATE, 16'h0006);
    overcurrent <= 3'h0;
    repeat (8) @(posedge ref_clk);
    wr(pwmcsc_pkg::ADDR_STATE_MOD, 16'h0001);
    rd(pwmcsc_pkg::ADDR_CMP_STATE, 16'h0007);
    exp_st = 3'h7;
    // compare value one, then zero: one last low tick, then full duty
    cmp[0] = 16'h0001;
    for (int p = 0; p < 3; p++) begin
      if (p == 1) cmp[0] = 16'h0000;
      wr(pwmcsc_pkg::ADDR_SHADOW0, cmp[0]);
      timer_shadow_transfer <= 1'b1;
      @(posedge ref_clk);
      timer_shadow_transfer <= 1'b0;
      for (int k = 0; k < 5; k++) tick(16'(k), 1'b0, 1'b1);
    end
    final_report();
  end
endmodule
bind pwmcsc_top pwmcsc_top_asserts chk (.ref_clk, .rst, .timer_count, .count_direction, .timer_run_bit,
  .timer_tick, .reg_wr, .hysteresis_input, .channel_match, .zero_match, .one_match, .channel_state_bit,
  .match_up_event, .match_down_event, .channel_pin);
